// *** verilog/prsd_pkg.sv ***
// Constants for the clock ratio strap decoder
package prsd_pkg;

  // ==========================================================================
  // Platform ratio strap codes
  localparam logic [3:0] PRSD_PLAT_R2 = 4'h2;
  localparam logic [3:0] PRSD_PLAT_R3 = 4'h3;
  localparam logic [3:0] PRSD_PLAT_R4 = 4'h4;
  localparam logic [3:0] PRSD_PLAT_R5 = 4'h5;
  localparam logic [3:0] PRSD_PLAT_R6 = 4'h6;
  localparam logic [3:0] PRSD_PLAT_R8 = 4'h8;

  // ==========================================================================
  // Core ratio strap codes
  localparam logic [4:0] PRSD_CORE_R20 = 5'h08;
  localparam logic [4:0] PRSD_CORE_R25 = 5'h0C;
  localparam logic [4:0] PRSD_CORE_R30 = 5'h10;

  // ==========================================================================
  // Core ratio held in halves: 2:1 is 4, 2.5:1 is 5, 3:1 is 6
  localparam logic [3:0] PRSD_HALF_R20 = 4'h4;
  localparam logic [3:0] PRSD_HALF_R25 = 4'h5;
  localparam logic [3:0] PRSD_HALF_R30 = 4'h6;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] PRSD_RATIO_RST = 4'h0;
  localparam logic [7:0] PRSD_DIV_RST   = 8'h02;

  // ==========================================================================
  // Capture sequence
  typedef enum logic [1:0] {
    PRSD_WAIT    = 2'b00,
    PRSD_CAPTURE = 2'b01,
    PRSD_HOLD    = 2'b10
  } prsd_state_e;

endpackage : prsd_pkg

// *** verilog/prsd_clk_div.sv ***
// Divider making a divided clock from the platform clock, square for even divides
`timescale 1ns/1ns
`default_nettype none
module prsd_clk_div
  import prsd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divide,
  // Divided clock
  output logic                  clk_out
);

  // ==========================================================================
  // Counter
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [DIV_W-1:0] div_eff;
  logic [DIV_W-1:0] half;
  logic             wrap;
  logic             next_clk;

  // Divide by zero or one is taken as two: a single-flop clock cannot go faster
  assign div_eff    = (divide < DIV_W'(2)) ? DIV_W'(2) : divide;
  assign half       = div_eff >> 1;
  assign wrap       = (count == div_eff - DIV_W'(1));
  assign next_count = wrap ? '0 : count + DIV_W'(1);
  assign next_clk   = (count < half);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      clk_out <= 1'b0;
    end else if (run) begin
      count   <= next_count;
      clk_out <= next_clk;
    end else begin
      count   <= '0;
      clk_out <= 1'b0;
    end
  end

endmodule : prsd_clk_div
`default_nettype wire

// *** verilog/prsd_top.sv ***
// Reset-time ratio strap decoder with memory and local bus clock dividers
// Behaviour
// - Sample platform straps, decode valid ratio codes
// - Platform codes outside table flagged reserved
// - Decode core straps: 2, 2.5, 3 to 1
// - Memory clock runs at half platform clock
// - Local bus clock is platform divided by divider, 0 and 1 taken as 2
`timescale 1ns/1ns
`default_nettype none
module prsd_top
  import prsd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Strap pins
  input  wire logic [3:0]       platform_ratio_straps,
  input  wire logic [3:0]       core_ratio_straps_high,
  input  wire logic             core_ratio_strap_low,
  // Local bus divider setting
  input  wire logic [DIV_W-1:0] local_bus_clock_divider,
  // Decoded ratios
  output logic [3:0]            platform_ratio,
  output logic                  platform_ratio_valid,
  output logic [3:0]            core_ratio_halves,
  output logic                  core_ratio_valid,
  output logic                  ratios_locked,
  // Derived clocks
  output logic                  memory_bus_clock,
  output logic                  local_bus_clock_outputs
);

  // ==========================================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Platform strap decode
  localparam int                      PLAT_CODES = 6;
  localparam logic [4*PLAT_CODES-1:0] PLAT_TABLE = {PRSD_PLAT_R8, PRSD_PLAT_R6,
                                                    PRSD_PLAT_R5, PRSD_PLAT_R4,
                                                    PRSD_PLAT_R3, PRSD_PLAT_R2};

  logic [PLAT_CODES-1:0] plat_hit;
  logic [3:0]            plat_dec;
  logic                  plat_ok;

  // One comparator per legal code; codes off the table stay reserved
  for (genvar g = 0; g < PLAT_CODES; g++) begin : g_plat_hit
    assign plat_hit[g] =
      (platform_ratio_straps == PLAT_TABLE[4*g +: 4]);
  end

  assign plat_ok  = |plat_hit;
  // Reserved codes never yield a ratio; no fallback since none exists
  assign plat_dec = plat_ok ? platform_ratio_straps : PRSD_RATIO_RST;

  // ==========================================================================
  // Core strap decode
  logic [4:0] core_code;
  logic [3:0] core_dec;
  logic       core_ok;
  logic       is_c20;
  logic       is_c25;
  logic       is_c30;

  assign core_code = {core_ratio_straps_high, core_ratio_strap_low};
  assign is_c20    = (core_code == PRSD_CORE_R20);
  assign is_c25    = (core_code == PRSD_CORE_R25);
  assign is_c30    = (core_code == PRSD_CORE_R30);
  assign core_ok   = is_c20 | is_c25 | is_c30;
  assign core_dec  = is_c20 ? PRSD_HALF_R20 :
                     is_c25 ? PRSD_HALF_R25 :
                     is_c30 ? PRSD_HALF_R30 : PRSD_RATIO_RST;

  // ==========================================================================
  // One-shot capture after reset release
  prsd_state_e state;
  prsd_state_e next_state;
  logic        take;

  assign take = (state == PRSD_CAPTURE);

  always_comb begin
    unique case (state)
      PRSD_WAIT:    next_state = PRSD_CAPTURE;
      PRSD_CAPTURE: next_state = PRSD_HOLD;
      PRSD_HOLD:    next_state = PRSD_HOLD;
      default:      next_state = PRSD_WAIT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PRSD_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Captured ratios
  logic [3:0] next_platform_ratio;
  logic       next_platform_ratio_valid;
  logic [3:0] next_core_ratio_halves;
  logic       next_core_ratio_valid;
  logic       next_ratios_locked;

  // Straps only sampled in the capture cycle; later pin changes ignored
  assign next_platform_ratio =
    take ? plat_dec : platform_ratio;
  assign next_platform_ratio_valid =
    take ? plat_ok : platform_ratio_valid;
  assign next_core_ratio_halves =
    take ? core_dec : core_ratio_halves;
  assign next_core_ratio_valid =
    take ? core_ok : core_ratio_valid;
  assign next_ratios_locked =
    take | ratios_locked;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      platform_ratio <= PRSD_RATIO_RST;
    end else begin
      platform_ratio <= next_platform_ratio;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      platform_ratio_valid <= 1'b0;
    end else begin
      platform_ratio_valid <= next_platform_ratio_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_ratio_halves <= PRSD_RATIO_RST;
    end else begin
      core_ratio_halves <= next_core_ratio_halves;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_ratio_valid <= 1'b0;
    end else begin
      core_ratio_valid <= next_core_ratio_valid;
    end
  end

  // Lock only falls with reset, so the ratios cannot be recaptured
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ratios_locked <= 1'b0;
    end else begin
      ratios_locked <= next_ratios_locked;
    end
  end

  // ==========================================================================
  // Memory bus clock: toggle each platform cycle
  logic next_memory_bus_clock;

  // Free running from reset release, not gated by the capture
  assign next_memory_bus_clock = ~memory_bus_clock;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memory_bus_clock <= 1'b0;
    end else begin
      memory_bus_clock <= next_memory_bus_clock;
    end
  end

  // ==========================================================================
  // Local bus clock
  logic [DIV_W-1:0] lb_div;
  logic             lb_clk;

  // Divider sampled each cycle; change causes one irregular period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lb_div <= DIV_W'(PRSD_DIV_RST);
    end else begin
      lb_div <= local_bus_clock_divider;
    end
  end

  prsd_clk_div #(
    .DIV_W (DIV_W)
  ) u_lb_div (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (ratios_locked),
    .divide  (lb_div),
    .clk_out (lb_clk)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      local_bus_clock_outputs <= 1'b0;
    end else begin
      local_bus_clock_outputs <= lb_clk;
    end
  end

endmodule : prsd_top
`default_nettype wire

// *** bench/prsd_strap_model.sv ***
// Board strap driver model for the ratio strap decoder
`timescale 1ns/1ns
`default_nettype none
module prsd_strap_model #(
  parameter int REF_MHZ      = 100,
  parameter int MEM_RATE_MHZ = 500,
  parameter int GMII_MHZ     = 119,
  parameter int ENC_MHZ      = 156
) (
  // Requested codes
  input  wire logic [3:0] plat_code,
  input  wire logic [4:0] core_code,
  // Strap pins
  output logic      [3:0] platform_ratio_straps,
  output logic      [3:0] core_ratio_straps_high,
  output logic            core_ratio_strap_low,
  // Board plan checks on the requested platform code
  output logic            mem_rate_ok,
  output logic            band_ok,
  output logic            gmii_ok,
  output logic            enc_ok
);
  int plat_mhz;

  // Straps always driven, since the decoder keeps no default
  assign platform_ratio_straps = plat_code;
  assign {core_ratio_straps_high, core_ratio_strap_low} = core_code;
  // Board plan, in MHz; FIFO limits scaled by ten to stay integer
  assign plat_mhz    = REF_MHZ * int'(plat_code);
  assign mem_rate_ok = (plat_mhz == MEM_RATE_MHZ);
  assign band_ok     = !(plat_mhz > 400 && plat_mhz < 500);
  assign gmii_ok     = (GMII_MHZ * 42 <= plat_mhz * 10);
  assign enc_ok      = (ENC_MHZ * 32 <= plat_mhz * 10);
endmodule : prsd_strap_model
`default_nettype wire

// *** bench/prsd_top_assertions.sv ***
// Checker for the ratio strap decoder ports
`timescale 1ns/1ns
`default_nettype none
module prsd_top_assertions
  import prsd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Strap pins and divider
  input  wire logic [3:0]       platform_ratio_straps,
  input  wire logic [3:0]       core_ratio_straps_high,
  input  wire logic             core_ratio_strap_low,
  input  wire logic [DIV_W-1:0] local_bus_clock_divider,
  // Decoded ratios and clocks
  input  wire logic [3:0]       platform_ratio,
  input  wire logic             platform_ratio_valid,
  input  wire logic [3:0]       core_ratio_halves,
  input  wire logic             core_ratio_valid,
  input  wire logic             ratios_locked,
  input  wire logic             memory_bus_clock,
  input  wire logic             local_bus_clock_outputs
);
  // Bound on the local clock high run, one above the 127 cycles of the widest divider
  localparam int LB_HIGH_MAX = 2 ** (DIV_W - 1);
  // ==========================================
  // Expected decode of the strap pins
  wire [4:0] core_code = {core_ratio_straps_high, core_ratio_strap_low};
  wire       plat_ok   = platform_ratio_straps inside {4'h2, 4'h3, 4'h4,
                         4'h5, 4'h6, 4'h8};
  wire [3:0] exp_half  = (core_code == 5'h08) ? 4'h4 :
                         (core_code == 5'h0C) ? 4'h5 :
                         (core_code == 5'h10) ? 4'h6 : 4'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_plat_decode: assert property ($rose(ratios_locked) |->
    platform_ratio == (plat_ok ? platform_ratio_straps : 4'h0))
    else $error("platform ratio decode differs");
  chk_plat_reserved: assert property ($rose(ratios_locked) |->
    platform_ratio_valid == plat_ok) else $error("platform valid differs");
  chk_core_decode: assert property ($rose(ratios_locked) |->
    core_ratio_halves == exp_half && core_ratio_valid == (exp_half != 4'h0))
    else $error("core ratio decode differs");
  chk_mem_half: assert property (ratios_locked |=>
    $changed(memory_bus_clock)) else $error("memory clock not toggling");
  chk_lb_idle: assert property (!ratios_locked |->
    !local_bus_clock_outputs) else $error("local clock before lock");
  chk_lb_high_len: assert property (ratios_locked &&
    local_bus_clock_outputs |-> ##[1:LB_HIGH_MAX] !local_bus_clock_outputs)
    else $error("local clock stuck high");
  chk_lock_hold: assert property (ratios_locked |=> ratios_locked &&
    $stable(platform_ratio) && $stable(core_ratio_halves))
    else $error("captured ratios changed");
endmodule : prsd_top_assertions
bind prsd_top prsd_top_assertions #(.DIV_W(DIV_W)) prsd_top_assertions_inst (
  .clock(clock), .resetn(resetn), .core_ratio_strap_low(core_ratio_strap_low),
  .platform_ratio_straps(platform_ratio_straps),
  .core_ratio_straps_high(core_ratio_straps_high),
  .local_bus_clock_divider(local_bus_clock_divider),
  .platform_ratio(platform_ratio), .core_ratio_halves(core_ratio_halves),
  .platform_ratio_valid(platform_ratio_valid),
  .core_ratio_valid(core_ratio_valid), .ratios_locked(ratios_locked),
  .memory_bus_clock(memory_bus_clock),
  .local_bus_clock_outputs(local_bus_clock_outputs));
`default_nettype wire

// *** bench/test_pll_ratio_strap_decode.sv ***
// Self-checking bench for the ratio strap decoder
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  miscompares++; $display("wrong value at %0t: got %0h", $time, got); end end
module test_pll_ratio_strap_decode import prsd_pkg::*;;
  logic       clock = 1'b0, resetn = 1'b0;
  logic [3:0] plat_code = 4'h2, plat_s, core_hi, ratio, halves;
  logic [4:0] core_code = 5'h08;
  logic [7:0] divider = 8'h02;
  logic       core_lo, plat_v, core_v, locked, mem_clk, lb_clk;
  logic       mem_ok, band_ok, gmii_ok, enc_ok, lb_prev, mem_prev;
  int         miscompares = 0, comparisons = 0, cycles = 0, highs, mems;
  int         lb_rises, mem_rises;
  always #5 clock = ~clock;
  prsd_strap_model prsd_strap_model_inst (.plat_code(plat_code),
    .core_code(core_code), .platform_ratio_straps(plat_s),
    .core_ratio_straps_high(core_hi), .core_ratio_strap_low(core_lo),
    .mem_rate_ok(mem_ok), .band_ok(band_ok), .gmii_ok(gmii_ok),
    .enc_ok(enc_ok));
  prsd_top prsd_top_inst (.clock(clock), .resetn(resetn),
    .platform_ratio_straps(plat_s), .core_ratio_straps_high(core_hi),
    .core_ratio_strap_low(core_lo), .local_bus_clock_divider(divider),
    .platform_ratio(ratio), .platform_ratio_valid(plat_v),
    .core_ratio_halves(halves), .core_ratio_valid(core_v),
    .ratios_locked(locked), .memory_bus_clock(mem_clk),
    .local_bus_clock_outputs(lb_clk));
  // ==========================================
  // Shared tasks
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      final_report();
    end
  end
  task reset_lock(input logic [3:0] p, input logic [4:0] c);
    @(posedge clock);
    plat_code <= p;
    core_code <= c;
    resetn    <= 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(negedge clock);
    `CHECK(locked, 1'b0)
    @(negedge clock);
    `CHECK(locked, 1'b1)
  endtask : reset_lock
  // ==========================================
  // Scenarios
  task check_platform;
    logic ok;
    for (int i = 0; i < 10; i++) begin
      ok = 4'(i) inside {PRSD_PLAT_R2, PRSD_PLAT_R3, PRSD_PLAT_R4,
                         PRSD_PLAT_R5, PRSD_PLAT_R6, PRSD_PLAT_R8};
      reset_lock(4'(i), PRSD_CORE_R30);
      `CHECK(plat_v, ok)
      `CHECK(ratio, ok ? 4'(i) : PRSD_RATIO_RST)
    end
  endtask : check_platform
  task check_core;
    logic [4:0] codes [7];
    logic [3:0] exp [7];
    codes = '{5'h08, 5'h0C, 5'h10, 5'h1C, 5'h14, 5'h0E, 5'h00};
    exp   = '{PRSD_HALF_R20, PRSD_HALF_R25, PRSD_HALF_R30, 4'h0, 4'h0,
              4'h0, 4'h0};
    for (int i = 0; i < 7; i++) begin
      reset_lock(PRSD_PLAT_R4, codes[i]);
      `CHECK(halves, exp[i])
      `CHECK(core_v, exp[i] != 4'h0)
    end
  endtask : check_core
  task check_hold_and_clocks(input logic [7:0] d, input int p);
    reset_lock(PRSD_PLAT_R5, PRSD_CORE_R25);
    `CHECK(mem_ok, 1'b1)
    `CHECK(band_ok, 1'b1)
    `CHECK(gmii_ok, 1'b1)
    `CHECK(enc_ok, 1'b1)
    @(posedge clock);
    plat_code <= PRSD_PLAT_R8;
    core_code <= PRSD_CORE_R20;
    divider   <= d;
    repeat (2 * p + 6) @(negedge clock);
    `CHECK(ratio, PRSD_PLAT_R5)
    `CHECK(halves, PRSD_HALF_R25)
    highs     = 0;
    mems      = 0;
    lb_rises  = 0;
    mem_rises = 0;
    lb_prev   = lb_clk;
    mem_prev  = mem_clk;
    // Window of whole periods, so phase does not matter
    for (int i = 0; i < 4 * p; i++) begin
      @(negedge clock);
      highs     += int'(lb_clk);
      mems      += int'(mem_clk);
      lb_rises  += int'(lb_clk & ~lb_prev);
      mem_rises += int'(mem_clk & ~mem_prev);
      lb_prev    = lb_clk;
      mem_prev   = mem_clk;
    end
    `CHECK(highs, 4 * (p / 2))
    `CHECK(lb_rises, 4)
    `CHECK(mems, 2 * p)
    `CHECK(mem_rises, 2 * p)
  endtask : check_hold_and_clocks
  initial begin
    check_platform();
    check_core();
    check_hold_and_clocks(8'h00, 2);
    check_hold_and_clocks(8'h05, 5);
    check_hold_and_clocks(8'h09, 9);
    final_report();
  end
endmodule : test_pll_ratio_strap_decode
`default_nettype wire
